// ### core/agc_regs.svh
// Register map, field positions and loop constants for the microphone gain loop.
// Assumes an 8-bit paged register port and a 15-bit Q1.15 magnitude domain.
`ifndef AGC_REGS_SVH
`define AGC_REGS_SVH

`define PAGE_CTRL         8'h00
`define PAGE_COEF         8'h04
`define OFS_COEF_N0_HI    7'h02
`define OFS_COEF_N0_LO    7'h03
`define OFS_COEF_N1_HI    7'h04
`define OFS_COEF_N1_LO    7'h05
`define OFS_COEF_D1_HI    7'h06
`define OFS_COEF_D1_LO    7'h07
`define OFS_LOOP_SAT      7'h24
`define OFS_CONV_SAT      7'h27
`define OFS_SILENCE       7'h2D
`define OFS_ENABLE_TARGET 7'h56
`define OFS_HYST_NOISE    7'h57
`define OFS_CEILING       7'h58
`define OFS_ATTACK        7'h59
`define OFS_DECAY         7'h5A
`define OFS_SIL_DEBOUNCE  7'h5B
`define OFS_SIG_DEBOUNCE  7'h5C
`define OFS_GAIN_READ     7'h5D

`define BIT_LOOP_SAT      5
`define BIT_CONV_SAT      3
`define BIT_SILENCE       6
`define BIT_ENABLE        7
`define TARGET_MSB        6
`define TARGET_LSB        4
`define HYST_MSB          7
`define HYST_LSB          6
`define NOISE_MSB         5
`define NOISE_LSB         1
`define CEIL_MSB          6
`define SIL_DEB_MSB       4
`define SIG_DEB_MSB       3

`define RST_COEF_N0       16'h7FFF
`define RST_COEF_N1       16'h0000
`define RST_COEF_D1       16'h0000
`define RST_BYTE          8'h00
`define COEF_SHIFT        15
`define AVG_MAX           15'h7FFF
// -30 dB of full scale; each further 3 codes halve the threshold (about 6 dB)
`define NOISE_BASE        15'h040C
`define NOISE_CODES_PER_HALF 3

`endif

// ### core/agc_pkg.sv
// Types shared by the microphone gain loop.
// Assumes agc_regs.svh carries every numeric constant except the target ladder, which mic_agc sets inline.
package agc_pkg;

    typedef struct packed {
        logic        strobe;
        logic        sat;
        logic [15:0] data;
    } sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] page;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic {
        ST_TRACK   = 1'b0,
        ST_SILENCE = 1'b1
    } loop_state_t;

endpackage : agc_pkg

// ### core/mic_agc.sv
// Automatic gain loop for the microphone record path.
// Assumes SAMPLE comes from same-clock logic, one strobe per converter sample.
`timescale 1ns/10ps
`include "agc_regs.svh"

module mic_agc
(
    input  wire logic              CLK,
    input  wire logic              RST_B,
    input  wire agc_pkg::sample_t  SAMPLE,
    input  wire logic [6:0]        FIXED_GAIN,
    input  wire agc_pkg::reg_req_t REG_REQ,
    output logic [7:0]             REG_RDATA,
    output logic [6:0]             MIC_PREAMP_GAIN
);

    logic [15:0]          n0_q, n1_q, d1_q;
    logic [7:0]           en_tgt_q, hyst_noise_q, ceil_reg_q;
    logic [7:0]           attack_q, decay_q, sil_deb_q, sig_deb_q;
    logic [14:0]          avg_q;
    logic [16:0]          abs_prev_q;
    logic [6:0]           gain_q, gain_d;
    logic [7:0]           rate_cnt_q, rate_cnt_d;
    logic [4:0]           deb_q;
    agc_pkg::loop_state_t state_q;
    logic                 loop_sat_q, conv_sat_q;

    logic                 loop_en;
    logic [6:0]           ceil;
    logic [14:0]          target, thr_enter, thr_exit;
    logic                 thr_on;
    logic [16:0]          abs_x;
    logic signed [35:0]   acc;
    logic [14:0]          avg_d;
    logic                 ctrl_wr, coef_wr;

    assign loop_en = en_tgt_q[`BIT_ENABLE];
    assign ceil    = ceil_reg_q[`CEIL_MSB:0];
    assign ctrl_wr = REG_REQ.wr && REG_REQ.page == `PAGE_CTRL;
    assign coef_wr = REG_REQ.wr && REG_REQ.page == `PAGE_COEF;

    // Target ladder, -5.5 dB down to -24 dB of full scale
    always_comb
    begin
        case (en_tgt_q[`TARGET_MSB:`TARGET_LSB])
            3'h0:    target = 15'h4420;
            3'h1:    target = 15'h32F5;
            3'h2:    target = 15'h287A;
            3'h3:    target = 15'h2026;
            3'h4:    target = 15'h198A;
            3'h5:    target = 15'h1215;
            3'h6:    target = 15'h0CCD;
            default: target = 15'h0812;
        endcase
    end

    // Code 0 turns silence detection off; hysteresis raises the exit level
    always_comb
    begin
        thr_on    = hyst_noise_q[`NOISE_MSB:`NOISE_LSB] != 5'h00;
        thr_enter = `NOISE_BASE >> ((hyst_noise_q[`NOISE_MSB:`NOISE_LSB] - 5'h01)
                    / `NOISE_CODES_PER_HALF);
        thr_exit  = thr_enter << hyst_noise_q[`HYST_MSB:`HYST_LSB];
    end

    // Averager: y = (N0*|x| + N1*|x'| + D1*y) / 2^15, clipped to positive range
    always_comb
    begin
        abs_x = SAMPLE.data[15] ? 17'(-$signed({SAMPLE.data[15], SAMPLE.data}))
                                : {1'b0, SAMPLE.data};
        acc   = 36'($signed(n0_q) * $signed({1'b0, abs_x}))
              + 36'($signed(n1_q) * $signed({1'b0, abs_prev_q}))
              + 36'($signed(d1_q) * $signed({2'b00, avg_q}));
        if (acc < 0)
            avg_d = 15'h0000;
        else if ((acc >>> `COEF_SHIFT) > 36'(`AVG_MAX))
            avg_d = `AVG_MAX;
        else
            avg_d = acc[`COEF_SHIFT +: 15];
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B || !loop_en)
        begin
            avg_q      <= 15'h0000;
            abs_prev_q <= 17'h00000;
        end
        else if (SAMPLE.strobe)
        begin
            avg_q      <= avg_d;
            abs_prev_q <= abs_x;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            n0_q <= `RST_COEF_N0;
            n1_q <= `RST_COEF_N1;
            d1_q <= `RST_COEF_D1;
        end
        else if (coef_wr)
        begin
            case (REG_REQ.addr)
                `OFS_COEF_N0_HI: n0_q[15:8] <= REG_REQ.wdata;
                `OFS_COEF_N0_LO: n0_q[7:0]  <= REG_REQ.wdata;
                `OFS_COEF_N1_HI: n1_q[15:8] <= REG_REQ.wdata;
                `OFS_COEF_N1_LO: n1_q[7:0]  <= REG_REQ.wdata;
                `OFS_COEF_D1_HI: d1_q[15:8] <= REG_REQ.wdata;
                `OFS_COEF_D1_LO: d1_q[7:0]  <= REG_REQ.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            en_tgt_q     <= `RST_BYTE;
            hyst_noise_q <= `RST_BYTE;
            ceil_reg_q   <= `RST_BYTE;
            attack_q     <= `RST_BYTE;
            decay_q      <= `RST_BYTE;
            sil_deb_q    <= `RST_BYTE;
            sig_deb_q    <= `RST_BYTE;
        end
        else if (ctrl_wr)
        begin
            case (REG_REQ.addr)
                `OFS_ENABLE_TARGET: en_tgt_q     <= REG_REQ.wdata;
                `OFS_HYST_NOISE:    hyst_noise_q <= REG_REQ.wdata;
                `OFS_CEILING:       ceil_reg_q   <= {1'b0, REG_REQ.wdata[`CEIL_MSB:0]};
                `OFS_ATTACK:        attack_q     <= REG_REQ.wdata;
                `OFS_DECAY:         decay_q      <= REG_REQ.wdata;
                `OFS_SIL_DEBOUNCE:  sil_deb_q    <= {3'h0, REG_REQ.wdata[`SIL_DEB_MSB:0]};
                `OFS_SIG_DEBOUNCE:  sig_deb_q    <= {4'h0, REG_REQ.wdata[`SIG_DEB_MSB:0]};
                default: ;
            endcase
        end
    end

    // Silence detector with debounce in both directions
    always_ff @(posedge CLK)
    begin
        if (!RST_B || !loop_en)
        begin
            state_q <= agc_pkg::ST_TRACK;
            deb_q   <= 5'h00;
        end
        else if (SAMPLE.strobe)
        begin
            case (state_q)
                agc_pkg::ST_TRACK:
                    if (thr_on && avg_q < thr_enter)
                    begin
                        if (deb_q == sil_deb_q[`SIL_DEB_MSB:0])
                        begin
                            state_q <= agc_pkg::ST_SILENCE;
                            deb_q   <= 5'h00;
                        end
                        else
                            deb_q <= deb_q + 5'h01;
                    end
                    else
                        deb_q <= 5'h00;
                agc_pkg::ST_SILENCE:
                    if (!thr_on || avg_q > thr_exit)
                    begin
                        if (deb_q == 5'(sig_deb_q[`SIG_DEB_MSB:0]))
                        begin
                            state_q <= agc_pkg::ST_TRACK;
                            deb_q   <= 5'h00;
                        end
                        else
                            deb_q <= deb_q + 5'h01;
                    end
                    else
                        deb_q <= 5'h00;
                default:
                begin
                    state_q <= agc_pkg::ST_TRACK;
                    deb_q   <= 5'h00;
                end
            endcase
        end
    end

    // Gain walk: a code of N gives one 0.5 dB step every N+1 samples
    always_comb
    begin
        gain_d     = gain_q;
        rate_cnt_d = rate_cnt_q;
        if (SAMPLE.strobe)
        begin
            if (state_q == agc_pkg::ST_SILENCE)
            begin
                rate_cnt_d = 8'h00;
                if (gain_q != 7'h00)
                    gain_d = gain_q - 7'h01;
            end
            else if (avg_q > target)
            begin
                if (rate_cnt_q >= attack_q)
                begin
                    rate_cnt_d = 8'h00;
                    if (gain_q != 7'h00)
                        gain_d = gain_q - 7'h01;
                end
                else
                    rate_cnt_d = rate_cnt_q + 8'h01;
            end
            else if (avg_q < target)
            begin
                if (rate_cnt_q >= decay_q)
                begin
                    rate_cnt_d = 8'h00;
                    if (gain_q < ceil)
                        gain_d = gain_q + 7'h01;
                end
                else
                    rate_cnt_d = rate_cnt_q + 8'h01;
            end
            else
                rate_cnt_d = 8'h00;
        end
        // A lowered ceiling takes hold at once, not on the next step
        if (gain_d > ceil)
            gain_d = ceil;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B || !loop_en)
        begin
            gain_q     <= 7'h00;
            rate_cnt_q <= 8'h00;
        end
        else
        begin
            gain_q     <= gain_d;
            rate_cnt_q <= rate_cnt_d;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            loop_sat_q      <= 1'b0;
            conv_sat_q      <= 1'b0;
            MIC_PREAMP_GAIN <= 7'h00;
        end
        else
        begin
            if (SAMPLE.strobe)
            begin
                loop_sat_q <= loop_en && state_q == agc_pkg::ST_TRACK
                              && avg_q < target && gain_q >= ceil;
                conv_sat_q <= SAMPLE.sat;
            end
            MIC_PREAMP_GAIN <= loop_en ? gain_q : FIXED_GAIN;
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            REG_RDATA <= 8'h00;
        else if (REG_REQ.rd)
        begin
            REG_RDATA <= 8'h00;
            if (REG_REQ.page == `PAGE_COEF)
                case (REG_REQ.addr)
                    `OFS_COEF_N0_HI: REG_RDATA <= n0_q[15:8];
                    `OFS_COEF_N0_LO: REG_RDATA <= n0_q[7:0];
                    `OFS_COEF_N1_HI: REG_RDATA <= n1_q[15:8];
                    `OFS_COEF_N1_LO: REG_RDATA <= n1_q[7:0];
                    `OFS_COEF_D1_HI: REG_RDATA <= d1_q[15:8];
                    `OFS_COEF_D1_LO: REG_RDATA <= d1_q[7:0];
                    default: ;
                endcase
            else if (REG_REQ.page == `PAGE_CTRL)
                case (REG_REQ.addr)
                    `OFS_LOOP_SAT:      REG_RDATA[`BIT_LOOP_SAT] <= loop_sat_q;
                    `OFS_CONV_SAT:      REG_RDATA[`BIT_CONV_SAT] <= conv_sat_q;
                    `OFS_SILENCE:       REG_RDATA[`BIT_SILENCE]  <= state_q;
                    `OFS_ENABLE_TARGET: REG_RDATA <= en_tgt_q;
                    `OFS_HYST_NOISE:    REG_RDATA <= hyst_noise_q;
                    `OFS_CEILING:       REG_RDATA <= ceil_reg_q;
                    `OFS_ATTACK:        REG_RDATA <= attack_q;
                    `OFS_DECAY:         REG_RDATA <= decay_q;
                    `OFS_SIL_DEBOUNCE:  REG_RDATA <= sil_deb_q;
                    `OFS_SIG_DEBOUNCE:  REG_RDATA <= sig_deb_q;
                    `OFS_GAIN_READ:     REG_RDATA <= {1'b0, gain_q};
                    default: ;
                endcase
        end
    end

    chk_gain_ceiling: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr |=> gain_q <= ceil)
        else $error("gain above ceiling");
    chk_silence_ramp: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr && SAMPLE.strobe && state_q == agc_pkg::ST_SILENCE
        && gain_q != 7'h00 |=> gain_q == $past(gain_q) - 7'h01)
        else $error("silence ramp not one step");
    chk_silence_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr && thr_on && state_q == agc_pkg::ST_SILENCE
        && !(avg_q > thr_exit) |=> state_q == agc_pkg::ST_SILENCE)
        else $error("silence left without signal");
    chk_step_size: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr && gain_q <= ceil |=> {1'b0, gain_q} <= {1'b0, $past(gain_q)} + 8'h01)
        else $error("gain step above half dB");
    chk_fixed_gain: assert property (@(posedge CLK) disable iff (!RST_B)
        !loop_en |=> MIC_PREAMP_GAIN == $past(FIXED_GAIN))
        else $error("fixed gain not applied");
    chk_sample_pace: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr && !$past(ctrl_wr) && !SAMPLE.strobe
        |=> $stable(gain_q) && $stable(avg_q)) else $error("gain moved between samples");
    chk_attack_step: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr && SAMPLE.strobe && state_q == agc_pkg::ST_TRACK
        && avg_q > target && rate_cnt_q >= attack_q && gain_q != 7'h00
        && gain_q <= ceil |=> gain_q == $past(gain_q) - 7'h01)
        else $error("attack step missing");
    chk_decay_step: assert property (@(posedge CLK) disable iff (!RST_B)
        loop_en && !ctrl_wr && SAMPLE.strobe && state_q == agc_pkg::ST_TRACK
        && avg_q < target && rate_cnt_q >= decay_q && gain_q < ceil
        |=> gain_q == $past(gain_q) + 7'h01)
        else $error("decay step missing");
    chk_disable_clear: assert property (@(posedge CLK) disable iff (!RST_B)
        !loop_en |=> gain_q == 7'h00 && state_q == agc_pkg::ST_TRACK)
        else $error("loop state not cleared");

endmodule : mic_agc

// ### test/adc_channel_model.sv
// Converter channel model: one signed sample per period into the gain loop.
// Assumes the bench sets amplitude and saturation; sign alternates per sample.
`timescale 1ns/10ps

module adc_channel_model
#(
    parameter int PERIOD = 4
)
(
    input  wire logic        clk,
    input  wire logic [15:0] amp,
    input  wire logic        sat,
    output agc_pkg::sample_t sample
);
    int   cnt;
    logic neg;

    initial
    begin
        cnt    = 0;
        neg    = 1'b0;
        sample = '0;
    end

    // Data off the strobe is scrambled so nothing can lean on a stale word
    always @(negedge clk)
    begin
        cnt = (cnt + 1) % PERIOD;
        sample.strobe <= (cnt == 0);
        sample.sat    <= sat;
        if (cnt == 0)
        begin
            neg = ~neg;
            sample.data <= neg ? -amp : amp;
        end
        else
        begin
            sample.data <= ~sample.data;
        end
    end
endmodule : adc_channel_model

// ### test/tb_top.sv
// Register-driven bench for the microphone gain loop.
// Assumes the converter model paces samples every four clocks.
`timescale 1ns/10ps
`include "agc_regs.svh"

module tb_top;
    typedef struct {
        logic [6:0]  wo;
        logic [7:0]  wd;
        logic [15:0] a;
        int          n;
        logic [6:0]  ro;
        logic [7:0]  ex;
    } step_t;

    logic              CLK;
    logic              RST_B;
    agc_pkg::sample_t  sample;
    agc_pkg::reg_req_t req;
    logic [6:0]        fixed_gain;
    logic [7:0]        rdata;
    logic [6:0]        gain;
    logic [15:0]       amp;
    logic              sat;
    int                n_fail;
    int                samples_checked;
    logic [7:0]        rw_exp [7] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h1F, 8'h0F};
    logic [7:0]        cfg    [7] = '{8'h00, 8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]        coef   [6] = '{8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    step_t             steps  [15] = '{
        '{7'h00, 8'h00, 16'h0800, 40, 7'h5D, 8'h10},
        '{7'h00, 8'h00, 16'h0800, 0,  7'h24, 8'h20},
        '{7'h58, 8'h08, 16'h0800, 1,  7'h5D, 8'h08},
        '{7'h00, 8'h00, 16'h7000, 20, 7'h5D, 8'h00},
        '{7'h00, 8'h00, 16'h0800, 20, 7'h5D, 8'h08},
        '{7'h00, 8'h00, 16'h0010, 20, 7'h2D, 8'h40},
        '{7'h00, 8'h00, 16'h0010, 10, 7'h5D, 8'h00},
        '{7'h00, 8'h00, 16'h0800, 20, 7'h2D, 8'h00},
        '{7'h57, 8'hC2, 16'h0010, 20, 7'h2D, 8'h40},
        '{7'h00, 8'h00, 16'h0800, 20, 7'h2D, 8'h40},
        '{7'h00, 8'h00, 16'h3000, 20, 7'h5D, 8'h08},
        '{7'h5B, 8'h1F, 16'h0010, 10, 7'h2D, 8'h00},
        '{7'h00, 8'h00, 16'h0010, 40, 7'h2D, 8'h40},
        '{7'h5C, 8'h0F, 16'h3000, 8,  7'h2D, 8'h40},
        '{7'h00, 8'h00, 16'h3000, 20, 7'h2D, 8'h00}};

    mic_agc i_mic_agc (.CLK(CLK), .RST_B(RST_B), .SAMPLE(sample), .FIXED_GAIN(fixed_gain),
        .REG_REQ(req), .REG_RDATA(rdata), .MIC_PREAMP_GAIN(gain));
    adc_channel_model i_adc_channel_model (.clk(CLK), .amp(amp), .sat(sat), .sample(sample));

    always #12.5 CLK = ~CLK;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Idle cycle after each access keeps the strobe from being set twice at one edge
    task automatic wr(input logic [7:0] pg, input logic [6:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: d};
        @(negedge CLK);
        req = '0;
        @(negedge CLK);
    endtask : wr

    task automatic chk(input logic [7:0] pg, input logic [6:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 8'h00};
        @(negedge CLK);
        req = '0;
        @(negedge CLK);
        check(rdata, exp);
    endtask : chk

    task automatic complete_run();
        $display("checks %0d, failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic wait_samples(input int n);
        int k;
        k = 0;
        for (int i = 0; i < n * 10 && k < n; i++)
        begin
            @(posedge CLK);
            if (sample.strobe === 1'b1)
            begin
                k++;
            end
        end
        if (k < n)
        begin
            n_fail++;
            complete_run();
        end
        @(negedge CLK);
    endtask : wait_samples

    initial
    begin
        CLK             = 1'b0;
        RST_B           = 1'b0;
        req             = '0;
        fixed_gain      = 7'h2A;
        amp             = 16'h0800;
        sat             = 1'b0;
        n_fail          = 0;
        samples_checked = 0;
        repeat (5) @(negedge CLK);
        RST_B = 1'b1;
        repeat (2) @(negedge CLK);
        check({1'b0, gain}, 8'h2A);
        chk(`PAGE_CTRL, 7'h24, 8'h00);
        chk(`PAGE_CTRL, 7'h27, 8'h00);
        chk(`PAGE_CTRL, 7'h2D, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            chk(`PAGE_CTRL, 7'h56 + 7'(i), 8'h00);
        end
        for (int i = 0; i < 6; i++)
        begin
            chk(`PAGE_COEF, 7'h02 + 7'(i), coef[i]);
            wr(`PAGE_COEF, 7'h02 + 7'(i), 8'hA0 + 8'(i));
            chk(`PAGE_COEF, 7'h02 + 7'(i), 8'hA0 + 8'(i));
            wr(`PAGE_COEF, 7'h02 + 7'(i), coef[i]);
        end
        for (int i = 0; i < 7; i++)
        begin
            wr(`PAGE_CTRL, 7'h56 + 7'(i), 8'hFF);
            chk(`PAGE_CTRL, 7'h56 + 7'(i), rw_exp[i]);
        end
        // Disable first so the loop restarts from a cleared state
        for (int i = 0; i < 7; i++)
        begin
            wr(`PAGE_CTRL, 7'h56 + 7'(i), cfg[i]);
        end
        wr(`PAGE_CTRL, 7'h5D, 8'hFF);
        chk(`PAGE_CTRL, 7'h5D, 8'h00);
        wr(`PAGE_CTRL, 7'h30, 8'h5A);
        chk(`PAGE_CTRL, 7'h30, 8'h00);
        chk(`PAGE_COEF, 7'h08, 8'h00);
        chk(8'h01, 7'h56, 8'h00);
        wr(`PAGE_CTRL, 7'h56, 8'h80);
        foreach (steps[i])
        begin
            wr(`PAGE_CTRL, steps[i].wo, steps[i].wd);
            amp = steps[i].a;
            wait_samples(steps[i].n);
            chk(`PAGE_CTRL, steps[i].ro, steps[i].ex);
        end
        check({1'b0, gain}, 8'h08);
        sat = 1'b1;
        wait_samples(2);
        chk(`PAGE_CTRL, 7'h27, 8'h08);
        sat = 1'b0;
        wait_samples(2);
        chk(`PAGE_CTRL, 7'h27, 8'h00);
        // Mid-run reset with the loop live must land in the disabled state
        RST_B = 1'b0;
        repeat (2) @(negedge CLK);
        RST_B = 1'b1;
        @(negedge CLK);
        check({1'b0, gain}, 8'h2A);
        chk(`PAGE_CTRL, 7'h5D, 8'h00);
        chk(`PAGE_CTRL, 7'h58, 8'h00);
        chk(`PAGE_CTRL, 7'h57, 8'h00);
        chk(`PAGE_CTRL, 7'h5C, 8'h00);
        wr(`PAGE_CTRL, 7'h56, 8'h80);
        fixed_gain = 7'h15;
        wr(`PAGE_CTRL, 7'h56, 8'h00);
        repeat (2) @(negedge CLK);
        check({1'b0, gain}, 8'h15);
        chk(`PAGE_CTRL, 7'h5D, 8'h00);
        complete_run();
    end
endmodule : tb_top
